// [inc/tmw_regs.vh]
// Register map, field positions and constants of the 8-bit waveform timer.
// Assumes byte-wide registers on a simple strobe port.
`ifndef TMW_REGS_VH
`define TMW_REGS_VH
`define TMW_ADDR_CTRL_A 8'hb0
`define TMW_ADDR_CTRL_B 8'hb1
`define TMW_ADDR_COUNT 8'hb2
`define TMW_ADDR_CMP_A 8'hb3
`define TMW_ADDR_CMP_B 8'hb4
`define TMW_ADDR_SRC 8'hb6
`define TMW_ADDR_FLAGS 8'hb7
`define TMW_ADDR_MASK 8'hb8
`define TMW_CTRL_A_RESET 8'h00
`define TMW_CTRL_B_RESET 8'h00
`define TMW_COUNT_RESET 8'h00
`define TMW_CTRL_A_MASK 8'hf3
`define TMW_CTRL_B_MASK 8'h0f
`define TMW_FOC_A_BIT 7
`define TMW_FOC_B_BIT 6
`define TMW_WGM_HIGH_BIT 3
`define TMW_ASYNC_BIT 5
`define TMW_FLAG_OVF 0
`define TMW_FLAG_CMPA 1
`define TMW_FLAG_CMPB 2
`define TMW_MAX 8'hff
`define TMW_BOTTOM 8'h00
`define TMW_DIV_8 10'h007
`define TMW_DIV_32 10'h01f
`define TMW_DIV_64 10'h03f
`define TMW_DIV_128 10'h07f
`define TMW_DIV_256 10'h0ff
`define TMW_DIV_1024 10'h3ff
`endif

// [src/tmw_timer.v]
// 8-bit timer/counter with waveform modes, two compare outputs and flags.
// Assumes a single-cycle strobe register port and a free running clock.
// What this block does
// - Phase-correct output B: 00 off, 01 reserved, 10/11 up/down set-clear.
// - Phase-correct B at TOP with action bit1: ignore match, act at TOP.
// - Control A bits 3:2 and control B bits 5:4 read as zero.
// - Three-bit waveform mode picks sequence, TOP and waveform; 4,6 reserved.
// - Mode 0: TOP 0xff, immediate compare update, overflow at MAX.
// - Mode 2: TOP is compare A, immediate update, overflow at MAX.
// - Modes 1,5 phase-correct: TOP 0xff or A, load at TOP, flag at BOTTOM.
// - Modes 3,7 fast PWM: load at BOTTOM; flag at MAX or TOP.
// - Force bits in non-PWM modes strike an immediate compare event.
// - Forced compare sets no flag and never clears the counter.
// - Force bits are write-only strobes reading zero.
// - Clock select: stop, undivided, or divide by 8..1024.
// - Counter register gives direct read and write of the count.
// - A counter write blocks compare matches on the next timer tick.
// - Non-PWM output action 01 toggle, 10 clear, 11 set on match.
// - Source clock is the main clock, or the oscillator pin if selected.
`timescale 1ns/1ps
`default_nettype none
`include "tmw_regs.vh"
module tmw_timer (
   input wire clock,
   input wire reset,
   input wire [7:0] address,
   input wire [7:0] write_data,
   input wire write_strobe,
   input wire read_strobe,
   output reg [7:0] read_data,
   input wire oscillator_input_pin,
   output reg compare_output_a,
   output reg compare_output_b,
   output wire output_a_enable,
   output wire output_b_enable,
   output wire interrupt
);
   reg [7:0] ctrl_a_reg;
   reg [7:0] ctrl_b_reg;
   reg [7:0] count_reg;
   reg [7:0] cmp_a_reg;
   reg [7:0] cmp_b_reg;
   reg [7:0] cmp_a_buf_reg;
   reg [7:0] cmp_b_buf_reg;
   reg async_reg;
   reg [2:0] flags_reg;
   reg [2:0] mask_reg;
   reg down_reg;
   reg block_reg;
   reg [9:0] pre_reg;
   reg [2:0] osc_sync_reg;
   wire [2:0] mode;
   wire [1:0] act_a;
   wire [1:0] act_b;
   wire wr_ctrl_a;
   wire wr_ctrl_b;
   wire wr_count;
   wire wr_src;
   wire wr_mask;
   wire wr_cmp_a;
   wire wr_cmp_b;
   wire wr_flags;
   wire src_tick;
   reg tick;
   reg [7:0] top;
   reg is_pwm;
   reg is_phase;
   reg is_fast;
   wire match_a;
   wire match_b;
   wire at_top;
   wire at_bottom;
   reg ovf_event;
   reg [7:0] count_next;
   reg down_next;
   reg out_a_next;
   reg out_b_next;
   wire force_a;
   wire force_b;

   // Output action on a compare match, selected by the waveform class
   function act_match;
      input [1:0] act;
      input cur;
      input pwm;
      input fast;
      input down;
      begin
         if (!pwm) begin
            case (act)
               2'b01: act_match = ~cur;
               2'b10: act_match = 1'b0;
               2'b11: act_match = 1'b1;
               default: act_match = cur;
            endcase
         end else if (act[1]) begin
            if (fast)
               act_match = act[0];
            else
               act_match = act[0] ^ down;
         end else begin
            act_match = cur;
         end
      end
   endfunction

   // Prescaler tap per clock select; the divider free-runs, so the
   // first tick after a select change may come early
   function presc_due;
      input [2:0] sel;
      input [9:0] pre;
      begin
         case (sel)
            3'd0: presc_due = 1'b0;
            3'd1: presc_due = 1'b1;
            3'd2: presc_due = (pre & `TMW_DIV_8) == `TMW_DIV_8;
            3'd3: presc_due = (pre & `TMW_DIV_32) == `TMW_DIV_32;
            3'd4: presc_due = (pre & `TMW_DIV_64) == `TMW_DIV_64;
            3'd5: presc_due = (pre & `TMW_DIV_128) == `TMW_DIV_128;
            3'd6: presc_due = (pre & `TMW_DIV_256) == `TMW_DIV_256;
            default: presc_due = pre == `TMW_DIV_1024;
         endcase
      end
   endfunction

   // One address compare shared by every register write
   function reg_hit;
      input strobe;
      input [7:0] addr;
      input [7:0] target;
      begin
         reg_hit = strobe && addr == target;
      end
   endfunction

   assign mode = {ctrl_b_reg[`TMW_WGM_HIGH_BIT], ctrl_a_reg[1:0]};
   assign act_a = ctrl_a_reg[7:6];
   assign act_b = ctrl_a_reg[5:4];
   assign wr_ctrl_a = reg_hit(write_strobe, address, `TMW_ADDR_CTRL_A);
   assign wr_ctrl_b = reg_hit(write_strobe, address, `TMW_ADDR_CTRL_B);
   assign wr_count = reg_hit(write_strobe, address, `TMW_ADDR_COUNT);
   assign wr_src = reg_hit(write_strobe, address, `TMW_ADDR_SRC);
   assign wr_mask = reg_hit(write_strobe, address, `TMW_ADDR_MASK);
   assign wr_cmp_a = reg_hit(write_strobe, address, `TMW_ADDR_CMP_A);
   assign wr_cmp_b = reg_hit(write_strobe, address, `TMW_ADDR_CMP_B);
   assign wr_flags = reg_hit(write_strobe, address, `TMW_ADDR_FLAGS);
   assign output_a_enable = ~(act_a != 2'b00);
   assign output_b_enable = ~(act_b != 2'b00);
   assign interrupt = |(flags_reg & mask_reg);

   // Oscillator pin is synchronised; its rising edge is one source tick
   assign src_tick = async_reg ? (osc_sync_reg[1] & ~osc_sync_reg[2])
                               : 1'b1;

   always @* begin
      tick = src_tick && presc_due(ctrl_b_reg[2:0], pre_reg);
   end

   always @* begin
      is_pwm = 1'b0;
      is_phase = 1'b0;
      is_fast = 1'b0;
      top = `TMW_MAX;
      case (mode)
         3'd1: begin
            is_pwm = 1'b1;
            is_phase = 1'b1;
         end
         3'd2: top = cmp_a_reg;
         3'd3: begin
            is_pwm = 1'b1;
            is_fast = 1'b1;
         end
         3'd5: begin
            is_pwm = 1'b1;
            is_phase = 1'b1;
            top = cmp_a_reg;
         end
         3'd7: begin
            is_pwm = 1'b1;
            is_fast = 1'b1;
            top = cmp_a_reg;
         end
         default: top = `TMW_MAX;
      endcase
   end

   assign at_top = count_reg == top;
   assign at_bottom = count_reg == `TMW_BOTTOM;
   // Matches are blocked on the tick after a counter write
   assign match_a = tick && !block_reg && count_reg == cmp_a_reg;
   // At TOP in phase-correct the match is replaced by the TOP action
   assign match_b = tick && !block_reg && count_reg == cmp_b_reg
                    && !(is_phase && act_b[1] && cmp_b_reg == top);
   assign force_a = wr_ctrl_b && write_data[`TMW_FOC_A_BIT] && !is_pwm;
   assign force_b = wr_ctrl_b && write_data[`TMW_FOC_B_BIT] && !is_pwm;

   always @* begin
      count_next = count_reg + 8'h01;
      down_next = down_reg;
      ovf_event = 1'b0;
      if (is_phase) begin
         if (down_reg) begin
            count_next = count_reg - 8'h01;
            if (at_bottom) begin
               count_next = count_reg + 8'h01;
               down_next = 1'b0;
               ovf_event = 1'b1;
            end
         end else if (at_top) begin
            count_next = count_reg - 8'h01;
            down_next = 1'b1;
         end
      end else begin
         if (at_top)
            count_next = `TMW_BOTTOM;
         ovf_event = is_fast && mode[2] ? at_top
                                        : count_reg == `TMW_MAX;
      end
   end

   always @* begin
      out_a_next = compare_output_a;
      out_b_next = compare_output_b;
      if (tick) begin
         if (match_a)
            out_a_next = act_match(act_a, compare_output_a, is_pwm,
                                   is_fast, down_reg);
         if (match_b)
            out_b_next = act_match(act_b, compare_output_b, is_pwm,
                                   is_fast, down_reg);
         // Fast PWM restores both outputs at BOTTOM; only A skips it when its match fired
         if (is_fast && at_top && act_a[1] && !match_a)
            out_a_next = ~act_a[0];
         if (is_fast && at_top && act_b[1])
            out_b_next = ~act_b[0];
         // Phase-correct B equal to TOP acts at TOP instead
         if (is_phase && act_b[1] && cmp_b_reg == top && at_top)
            out_b_next = act_b[0];
      end
      if (force_a)
         out_a_next = act_match(act_a, compare_output_a, 1'b0, 1'b0, 1'b0);
      if (force_b)
         out_b_next = act_match(act_b, compare_output_b, 1'b0, 1'b0, 1'b0);
   end

   always @(posedge clock or posedge reset) begin
      if (reset) begin
         ctrl_a_reg <= `TMW_CTRL_A_RESET;
         ctrl_b_reg <= `TMW_CTRL_B_RESET;
         async_reg <= 1'b0;
         mask_reg <= 3'h0;
      end else begin
         if (wr_ctrl_a)
            ctrl_a_reg <= write_data & `TMW_CTRL_A_MASK;
         // Force bits are masked off here so they never read back
         if (wr_ctrl_b)
            ctrl_b_reg <= write_data & `TMW_CTRL_B_MASK;
         if (wr_src)
            async_reg <= write_data[`TMW_ASYNC_BIT];
         if (wr_mask)
            mask_reg <= write_data[2:0];
      end
   end

   always @(posedge clock or posedge reset) begin
      if (reset) begin
         cmp_a_reg <= 8'h00;
         cmp_b_reg <= 8'h00;
         cmp_a_buf_reg <= 8'h00;
         cmp_b_buf_reg <= 8'h00;
      end else begin
         if (wr_cmp_a)
            cmp_a_buf_reg <= write_data;
         if (wr_cmp_b)
            cmp_b_buf_reg <= write_data;
         // Buffered compare values load per mode; non-PWM loads at once
         if (!is_pwm) begin
            cmp_a_reg <= cmp_a_buf_reg;
            cmp_b_reg <= cmp_b_buf_reg;
         end else if (tick && ((is_phase && at_top) ||
                               (is_fast && at_top))) begin
            cmp_a_reg <= cmp_a_buf_reg;
            cmp_b_reg <= cmp_b_buf_reg;
         end
      end
   end

   // Only true matches and overflow set flags; set beats clear
   always @(posedge clock or posedge reset) begin
      if (reset)
         flags_reg <= 3'h0;
      else
         flags_reg <= (flags_reg & ~(wr_flags ? write_data[2:0] : 3'h0))
                      | {match_b, match_a, tick && ovf_event};
   end

   always @(posedge clock or posedge reset) begin
      if (reset) begin
         count_reg <= `TMW_COUNT_RESET;
         down_reg <= 1'b0;
         block_reg <= 1'b0;
         pre_reg <= 10'h000;
         osc_sync_reg <= 3'h0;
         compare_output_a <= 1'b0;
         compare_output_b <= 1'b0;
      end else begin
         osc_sync_reg <= {osc_sync_reg[1:0], oscillator_input_pin};
         if (src_tick)
            pre_reg <= pre_reg + 10'h001;
         compare_output_a <= out_a_next;
         compare_output_b <= out_b_next;
         // A count write wins over a tick in the same cycle
         if (wr_count) begin
            count_reg <= write_data;
            block_reg <= 1'b1;
         end else if (tick) begin
            count_reg <= count_next;
            down_reg <= down_next;
            block_reg <= 1'b0;
         end
         if (!is_phase)
            down_reg <= 1'b0;
      end
   end

   always @(posedge clock or posedge reset) begin
      if (reset)
         read_data <= 8'h00;
      else if (read_strobe) begin
         case (address)
            `TMW_ADDR_CTRL_A: read_data <= ctrl_a_reg;
            `TMW_ADDR_CTRL_B: read_data <= ctrl_b_reg;
            `TMW_ADDR_COUNT: read_data <= count_reg;
            `TMW_ADDR_CMP_A: read_data <= cmp_a_buf_reg;
            `TMW_ADDR_CMP_B: read_data <= cmp_b_buf_reg;
            `TMW_ADDR_SRC: read_data <= {2'b00, async_reg, 5'h00};
            `TMW_ADDR_FLAGS: read_data <= {5'h00, flags_reg};
            `TMW_ADDR_MASK: read_data <= {5'h00, mask_reg};
            default: read_data <= 8'h00;
         endcase
      end else
         read_data <= 8'h00;
   end
endmodule // tmw_timer
`default_nettype wire

// [verification/tmw_props.sv]
// Port checker for the waveform timer.
// Assumes a bind onto tmw_timer; strobes last one cycle.
`timescale 1ns/1ps
`default_nettype none
module tmw_props (
   input wire logic clock,
   input wire logic reset,
   input wire logic [7:0] address,
   input wire logic [7:0] write_data,
   input wire logic write_strobe,
   input wire logic read_strobe,
   input wire logic [7:0] read_data,
   input wire logic oscillator_input_pin,
   input wire logic compare_output_a,
   input wire logic compare_output_b,
   input wire logic output_a_enable,
   input wire logic output_b_enable,
   input wire logic interrupt
);
   // Shadow of control A; bit 0 alone tells PWM from non-PWM
   logic [7:0] cta_reg;
   logic irq_wr_reg;
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         cta_reg <= 8'h00;
         irq_wr_reg <= 1'b0;
      end else begin
         if (write_strobe && address == 8'hb0)
            cta_reg <= write_data;
         irq_wr_reg <= write_strobe && (address == 8'hb7 || address == 8'hb8);
      end
   end
   default clocking @(posedge clock);
   endclocking
   default disable iff (reset);
   sequence rd_at(a);
      read_strobe && address == a;
   endsequence
   sequence frc_a;
      write_strobe && address == 8'hb1 && write_data[7] && !cta_reg[0]
         && cta_reg[7];
   endsequence
   sequence frc_b;
      write_strobe && address == 8'hb1 && write_data[6] && !cta_reg[0]
         && cta_reg[5];
   endsequence
   chk_read_idle:
   assert property (!read_strobe |=> read_data == 8'h00)
      else $error("read data not zero outside a read");
   chk_ctrl_b_zero:
   assert property (rd_at(8'hb1) |=> read_data[7:4] == 4'h0)
      else $error("control B upper bits not zero");
   chk_ctrl_a_back:
   assert property (rd_at(8'hb0) |=> read_data == (cta_reg & 8'hf3))
      else $error("control A readback wrong");
   chk_enable_a:
   assert property (output_a_enable == (cta_reg[7:6] == 2'b00))
      else $error("output A enable wrong");
   chk_enable_b:
   assert property (output_b_enable == (cta_reg[5:4] == 2'b00))
      else $error("output B enable wrong");
   chk_irq_fall:
   assert property ($fell(interrupt) |-> irq_wr_reg || $past(irq_wr_reg))
      else $error("interrupt fell without flag or mask write");
   chk_force_a:
   assert property (frc_a |=> ##[0:1] compare_output_a == cta_reg[6])
      else $error("forced compare A level wrong");
   chk_force_b:
   assert property (frc_b |=> ##[0:1] compare_output_b == cta_reg[4])
      else $error("forced compare B level wrong");
endmodule // tmw_props
`default_nettype wire

// [verification/tb_top.sv]
// Self-checking bench for the waveform timer register port.
// Assumes the design and its register header compile first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic [7:0] address = 8'h00;
   logic [7:0] write_data = 8'h00;
   logic write_strobe = 1'b0;
   logic read_strobe = 1'b0;
   logic osc = 1'b0;
   wire [7:0] read_data;
   wire out_a, out_b, en_a, en_b, interrupt;
   integer miscompares = 0;
   integer checked = 0;
   integer i;
   integer dv [8] = '{1, 1, 8, 32, 64, 128, 256, 1024};
   logic [7:0] v, w;
   always #25 clock = ~clock;
   tmw_timer uut (.clock(clock), .reset(reset), .address(address),
      .write_data(write_data), .write_strobe(write_strobe),
      .read_strobe(read_strobe), .read_data(read_data),
      .oscillator_input_pin(osc), .compare_output_a(out_a),
      .compare_output_b(out_b), .output_a_enable(en_a),
      .output_b_enable(en_b), .interrupt(interrupt));
   task check(input logic [7:0] seen, input logic [7:0] exp);
      checked = checked + 1;
      if (seen !== exp) begin
         miscompares = miscompares + 1;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      address <= a;
      write_data <= d;
      write_strobe <= 1'b1;
      @(posedge clock);
      write_strobe <= 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      address <= a;
      read_strobe <= 1'b1;
      @(posedge clock);
      read_strobe <= 1'b0;
      #1 d = read_data;
   endtask
   task settle;
      @(posedge clock);
      #1;
   endtask
   task results;
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clock);
      reset <= 1'b0;
      settle();
      check({en_a, en_b, out_a, out_b, interrupt}, 8'h18);
      for (i = 0; i < 3; i = i + 1) begin
         rd(8'hb0 + i[7:0], v);
         check(v, 8'h00);
      end
      wr(8'hb0, 8'hff);
      rd(8'hb0, v);
      check(v, 8'hf3);
      wr(8'hb1, 8'h30);
      rd(8'hb1, v);
      check(v, 8'h00);
      // Set, clear, then toggle from low: ends known whatever the start
      for (i = 3; i > 0; i = i - 1) begin
         wr(8'hb0, {i[1:0], i[1:0], 4'h0});
         wr(8'hb1, 8'hc0);
         settle();
         check({en_a, en_b, out_a, out_b}, {2'b00, {2{i != 2}}});
      end
      rd(8'hb1, v);
      check(v, 8'h00);
      rd(8'hb7, v);
      check(v, 8'h00);
      wr(8'hb0, 8'h00);
      wr(8'hb2, 8'ha5);
      rd(8'hb2, v);
      check(v, 8'ha5);
      // Spacing of two prescaler periods gives two ticks at any phase
      for (i = 0; i < 8; i = i + 1) begin
         wr(8'hb1, i[7:0]);
         rd(8'hb2, v);
         repeat (2 * dv[i] - 2) @(posedge clock);
         rd(8'hb2, w);
         check(w - v, (i == 0) ? 8'h00 : 8'h02);
      end
      wr(8'hb1, 8'h00);
      wr(8'hb7, 8'h07);
      wr(8'hb8, 8'h01);
      wr(8'hb2, 8'hfc);
      wr(8'hb1, 8'h01);
      for (i = 0; i < 20 && interrupt !== 1'b1; i = i + 1) begin
         @(posedge clock);
         #1;
      end
      check({7'h00, i < 20}, 8'h01);
      if (i == 20)
         results();
      wr(8'hb1, 8'h00);
      wr(8'hb8, 8'h00);
      settle();
      check({7'h00, interrupt}, 8'h00);
      rd(8'hb7, v);
      check(v & 8'h01, 8'h01);
      wr(8'hb8, 8'h01);
      settle();
      check({7'h00, interrupt}, 8'h01);
      wr(8'hb7, 8'h07);
      settle();
      check({7'h00, interrupt}, 8'h00);
      wr(8'hb0, 8'h02);
      wr(8'hb3, 8'h05);
      wr(8'hb2, 8'h00);
      wr(8'hb1, 8'h01);
      for (i = 0; i < 8; i = i + 1) begin
         rd(8'hb2, v);
         check({7'h00, v > 8'h05}, 8'h00);
      end
      // Phase-correct from 0xf0: B set going down at 0x40, cleared going up
      wr(8'hb1, 8'h00);
      wr(8'hb0, 8'h20);
      wr(8'hb1, 8'h40);
      wr(8'hb0, 8'h21);
      wr(8'hb4, 8'h40);
      wr(8'hb2, 8'hf0);
      wr(8'hb7, 8'h07);
      wr(8'hb1, 8'h01);
      repeat (150) @(posedge clock);
      rd(8'hb7, v);
      check({v[0], 6'h00, out_b}, 8'h00);
      repeat (90) @(posedge clock);
      settle();
      check({7'h00, out_b}, 8'h01);
      rd(8'hb7, v);
      check(v & 8'h01, 8'h00);
      repeat (50) @(posedge clock);
      rd(8'hb7, v);
      check(v & 8'h01, 8'h01);
      repeat (60) @(posedge clock);
      settle();
      check({7'h00, out_b}, 8'h00);
      // A count write removes the match on the next tick only
      wr(8'hb1, 8'h00);
      wr(8'hb0, 8'h00);
      wr(8'hb3, 8'h10);
      wr(8'hb2, 8'h10);
      wr(8'hb7, 8'h07);
      wr(8'hb1, 8'h01);
      rd(8'hb7, v);
      check(v & 8'h02, 8'h00);
      wr(8'hb1, 8'h00);
      wr(8'hb2, 8'h0f);
      wr(8'hb1, 8'h01);
      settle();
      rd(8'hb7, v);
      check(v & 8'h02, 8'h02);
      // Oscillator pin as source: three rising edges give three counts
      wr(8'hb1, 8'h00);
      wr(8'hb2, 8'h00);
      wr(8'hb6, 8'h20);
      wr(8'hb1, 8'h01);
      for (i = 0; i < 3; i = i + 1) begin
         osc <= 1'b1;
         repeat (4) @(posedge clock);
         osc <= 1'b0;
         repeat (4) @(posedge clock);
      end
      rd(8'hb2, v);
      check(v, 8'h03);
      rd(8'hb6, v);
      check(v, 8'h20);
      results();
   end
endmodule // tb_top
bind tmw_timer tmw_props chk (.clock(clock), .reset(reset),
   .address(address), .write_data(write_data),
   .write_strobe(write_strobe), .read_strobe(read_strobe),
   .read_data(read_data), .oscillator_input_pin(oscillator_input_pin),
   .compare_output_a(compare_output_a), .compare_output_b(compare_output_b),
   .output_a_enable(output_a_enable), .output_b_enable(output_b_enable),
   .interrupt(interrupt));
`default_nettype wire
